// [pkg/irf_pkg.sv]
// Package: constants and types of the interrupt request flag block
package irf_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_EXT_FLAGS   = 4'h0;
  localparam logic [3:0] OFF_DMA_IR      = 4'h1;
  localparam logic [3:0] OFF_CONV_SER    = 4'h2;
  localparam logic [3:0] OFF_LINE_SENSE  = 4'h3;
  localparam logic [3:0] OFF_PORT_SENSE  = 4'h4;
  localparam logic [3:0] OFF_PORT_ENABLE = 4'h5;
  localparam logic [3:0] OFF_IRQ_STATUS  = 4'h6;
  localparam logic [3:0] OFF_IRQ_MASK    = 4'h7;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int EXT_LINES      = 6;
  localparam int PORT_PINS      = 16;
  localparam int PORT_GROUP     = 8;
  localparam int BIT_PORT_LOW   = 7;
  localparam int BIT_PORT_HIGH  = 6;
  localparam int BIT_CONV_END   = 4;
  localparam int SYNC_W         = EXT_LINES + PORT_PINS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [11:0] LINE_SENSE_RST = 12'h000;
  localparam logic [15:0] PORT_CFG_RST = 16'h0000;
  localparam logic [7:0]  IRQ_RST = 8'h00;

  // ----------------------------------------------------------------
  // Sense code of an external request line
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IRF_SENSE_FALL = 2'b00,
    IRF_SENSE_RISE = 2'b01,
    IRF_SENSE_LOW  = 2'b10,
    IRF_SENSE_RSVD = 2'b11
  } irf_sense_e;

endpackage

// [pkg/irf_sync_if.sv]
// Interface: raw pin levels in, filtered levels out of the synchroniser
`timescale 1ns/1ps
interface irf_sync_if #(
  parameter int N = 22
);
  logic [N-1:0] raw;
  logic [N-1:0] clean;

  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

// [src/irf_sync.sv]
// Module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module irf_sync #(
  parameter int N = 22
) (
  input wire logic          clock,
  input wire logic          srst,
  irf_sync_if.sync_side     pins
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Reset to ones: idle request lines sit high, so no false edge
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;
  logic [N-1:0] clean_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= pins.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      clean_reg <= '1;
    end else begin
      clean_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & clean_reg);
    end
  end

  assign pins.clean = clean_reg;

endmodule

// [src/irf_top.sv]
// Module: interrupt request flag registers with register port and interrupt
`timescale 1ns/1ps
module irf_top (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       manual_reset,
  input  wire logic                       standby,
  input  wire logic [5:0]                 ext_request_line,
  input  wire logic [15:0]                port_level_interrupt_pin,
  input  wire logic [3:0]                 dma_end_req,
  input  wire logic [3:0]                 infrared_req,
  input  wire logic [3:0]                 fifo_serial_req,
  input  wire logic                       conversion_end_req,
  input  wire logic [irf_pkg::ADDR_W-1:0] addr,
  input  wire logic [irf_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [irf_pkg::DATA_W-1:0] rd_data,
  output logic                            irq,
  output logic      [7:0]                 external_request_flags,
  output logic      [7:0]                 dma_infrared_request_flags,
  output logic      [7:0]                 converter_serial_request_flags
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic irf_hit(
    input logic [irf_pkg::ADDR_W-1:0] a,
    input logic [3:0]                 off
  );
    irf_hit = (a == off);
  endfunction

  logic wr_ext;
  logic rd_ext;
  logic wr_line_sense;
  logic wr_port_sense;
  logic wr_port_enable;
  logic wr_mask;
  logic rd_status;

  assign wr_ext         = wr_en & irf_hit(addr, irf_pkg::OFF_EXT_FLAGS);
  assign rd_ext         = rd_en & irf_hit(addr, irf_pkg::OFF_EXT_FLAGS);
  assign wr_line_sense  = wr_en & irf_hit(addr, irf_pkg::OFF_LINE_SENSE);
  assign wr_port_sense  = wr_en & irf_hit(addr, irf_pkg::OFF_PORT_SENSE);
  assign wr_port_enable = wr_en & irf_hit(addr, irf_pkg::OFF_PORT_ENABLE);
  assign wr_mask        = wr_en & irf_hit(addr, irf_pkg::OFF_IRQ_MASK);
  assign rd_status      = rd_en & irf_hit(addr, irf_pkg::OFF_IRQ_STATUS);

  // Both resets clear flags and configuration alike
  logic any_reset;
  assign any_reset = srst | manual_reset;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  irf_sync_if #(.N(irf_pkg::SYNC_W)) pins_if ();

  assign pins_if.raw = {port_level_interrupt_pin, ext_request_line};

  irf_sync #(.N(irf_pkg::SYNC_W)) u_sync (
    .clock (clock),
    .srst  (srst),
    .pins  (pins_if.sync_side)
  );

  logic [5:0]  line_now;
  logic [15:0] port_now;

  assign line_now = pins_if.clean[irf_pkg::EXT_LINES-1:0];
  assign port_now = pins_if.clean[irf_pkg::SYNC_W-1:irf_pkg::EXT_LINES];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [11:0] line_sense_code_reg;
  logic [15:0] port_pin_sense_select_reg;
  logic [15:0] port_pin_enable_reg;

  always_ff @(posedge clock) begin
    if (any_reset) begin
      line_sense_code_reg <= irf_pkg::LINE_SENSE_RST;
    end else if (wr_line_sense) begin
      line_sense_code_reg <= wr_data[11:0];
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      port_pin_sense_select_reg <= irf_pkg::PORT_CFG_RST;
    end else if (wr_port_sense) begin
      port_pin_sense_select_reg <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      port_pin_enable_reg <= irf_pkg::PORT_CFG_RST;
    end else if (wr_port_enable) begin
      port_pin_enable_reg <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Sense decode
  // ----------------------------------------------------------------
  // Reserved code detects nothing, so a stray 11 cannot raise a flag
  function automatic logic irf_edge_seen(
    input logic [1:0] code,
    input logic       prev_lvl,
    input logic       cur_lvl
  );
    irf_edge_seen = 1'b0;
    unique case (irf_pkg::irf_sense_e'(code))
      irf_pkg::IRF_SENSE_FALL: irf_edge_seen = prev_lvl & ~cur_lvl;
      irf_pkg::IRF_SENSE_RISE: irf_edge_seen = ~prev_lvl & cur_lvl;
      irf_pkg::IRF_SENSE_LOW:  irf_edge_seen = 1'b0;
      irf_pkg::IRF_SENSE_RSVD: irf_edge_seen = 1'b0;
    endcase
  endfunction

  function automatic logic irf_level_mode(
    input logic [1:0] code
  );
    irf_level_mode = (irf_pkg::irf_sense_e'(code) == irf_pkg::IRF_SENSE_LOW);
  endfunction

  // ----------------------------------------------------------------
  // External request lines
  // ----------------------------------------------------------------
  logic [5:0] ext_line_flag_reg;
  logic [5:0] ext_line_flag_next;
  logic [5:0] armed_reg;
  logic [5:0] line_prev_reg;

  genvar gi;
  generate
    for (gi = 0; gi < irf_pkg::EXT_LINES; gi++) begin : g_line
      logic set_edge;
      logic follow_level;
      logic clear_req;
      always_comb begin
        set_edge     = irf_edge_seen(line_sense_code_reg[2*gi+1:2*gi],
                                     line_prev_reg[gi], line_now[gi]);
        follow_level = irf_level_mode(line_sense_code_reg[2*gi+1:2*gi]);
        // Only a 0 written after a read that saw 1 clears; 1 keeps it
        clear_req = wr_ext & ~wr_data[gi] & armed_reg[gi];
        if (follow_level) begin
          ext_line_flag_next[gi] = ~line_now[gi];
        end else begin
          // Set wins over a clear in the same cycle
          ext_line_flag_next[gi] = set_edge |
                                   (ext_line_flag_reg[gi] & ~clear_req);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      line_prev_reg <= '1;
    end else begin
      line_prev_reg <= line_now;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      ext_line_flag_reg <= irf_pkg::FLAGS_RST[5:0];
    end else if (!standby) begin
      ext_line_flag_reg <= ext_line_flag_next;
    end
  end

  // A read arms each bit it saw as 1; any write to the external flag offset consumes the arming
  always_ff @(posedge clock) begin
    if (any_reset) begin
      armed_reg <= '0;
    end else if (wr_ext) begin
      armed_reg <= '0;
    end else if (rd_ext) begin
      armed_reg <= armed_reg | ext_line_flag_reg;
    end
  end

  // ----------------------------------------------------------------
  // Port level interrupt pins
  // ----------------------------------------------------------------
  logic [15:0] port_req;
  logic        port_group_low_flag_reg;
  logic        port_group_high_flag_reg;

  assign port_req = port_pin_enable_reg &
                    ~(port_now ^ port_pin_sense_select_reg);

  always_ff @(posedge clock) begin
    if (any_reset) begin
      port_group_low_flag_reg  <= 1'b0;
      port_group_high_flag_reg <= 1'b0;
    end else if (!standby) begin
      port_group_low_flag_reg  <= |port_req[irf_pkg::PORT_GROUP-1:0];
      port_group_high_flag_reg <= |port_req[irf_pkg::PORT_PINS-1:irf_pkg::PORT_GROUP];
    end
  end

  // ----------------------------------------------------------------
  // Peripheral request mirrors
  // ----------------------------------------------------------------
  // Bus writes never reach these; they only track their sources
  logic [7:0] dma_ir_reg;
  logic [7:0] conv_ser_reg;

  always_ff @(posedge clock) begin
    if (any_reset) begin
      dma_ir_reg <= irf_pkg::FLAGS_RST;
    end else if (!standby) begin
      dma_ir_reg <= {infrared_req, dma_end_req};
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      conv_ser_reg <= irf_pkg::FLAGS_RST;
    end else if (!standby) begin
      conv_ser_reg <= {3'h0, conversion_end_req, fifo_serial_req};
    end
  end

  // ----------------------------------------------------------------
  // Assembled external flag byte
  // ----------------------------------------------------------------
  logic [7:0] ext_flags;

  assign ext_flags = {port_group_low_flag_reg, port_group_high_flag_reg, ext_line_flag_reg};

  assign external_request_flags         = ext_flags;
  assign dma_infrared_request_flags     = dma_ir_reg;
  assign converter_serial_request_flags = conv_ser_reg;

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  logic [7:0] ext_flags_prev_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [7:0] irq_mask_reg;
  logic       irq_reg;

  always_ff @(posedge clock) begin
    if (any_reset) begin
      ext_flags_prev_reg <= irf_pkg::FLAGS_RST;
    end else begin
      ext_flags_prev_reg <= ext_flags;
    end
  end

  // A rise arriving with the clearing read still sets its bit
  always_comb begin
    irq_status_next = rd_status ? irf_pkg::IRQ_RST : irq_status_reg;
    irq_status_next = irq_status_next | (ext_flags & ~ext_flags_prev_reg);
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      irq_status_reg <= irf_pkg::IRQ_RST;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      irq_mask_reg <= irf_pkg::IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; data stand one cycle after the strobe
  logic [irf_pkg::DATA_W-1:0] rd_mux;
  logic [irf_pkg::DATA_W-1:0] rd_data_reg;

  always_comb begin
    rd_mux = '0;
    unique case (addr)
      irf_pkg::OFF_EXT_FLAGS:   rd_mux = {8'h00, ext_flags};
      irf_pkg::OFF_DMA_IR:      rd_mux = {8'h00, dma_ir_reg};
      irf_pkg::OFF_CONV_SER:    rd_mux = {8'h00, conv_ser_reg};
      irf_pkg::OFF_LINE_SENSE:  rd_mux = {4'h0, line_sense_code_reg};
      irf_pkg::OFF_PORT_SENSE:  rd_mux = port_pin_sense_select_reg;
      irf_pkg::OFF_PORT_ENABLE: rd_mux = port_pin_enable_reg;
      irf_pkg::OFF_IRQ_STATUS:  rd_mux = {8'h00, irq_status_reg};
      irf_pkg::OFF_IRQ_MASK:    rd_mux = {8'h00, irq_mask_reg};
      default:                  rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_reg <= '0;
    end else if (rd_en) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= '0;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

// [bench/irf_props.sv]
// Checker: concurrent properties on the request flag block ports
`timescale 1ns/1ps
module irf_props (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       manual_reset,
  input wire logic                       standby,
  input wire logic [5:0]                 ext_request_line,
  input wire logic [15:0]                port_level_interrupt_pin,
  input wire logic [3:0]                 dma_end_req,
  input wire logic [3:0]                 infrared_req,
  input wire logic [3:0]                 fifo_serial_req,
  input wire logic                       conversion_end_req,
  input wire logic [irf_pkg::ADDR_W-1:0] addr,
  input wire logic [irf_pkg::DATA_W-1:0] wr_data,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [irf_pkg::DATA_W-1:0] rd_data,
  input wire logic                       irq,
  input wire logic [7:0]                 external_request_flags,
  input wire logic [7:0]                 dma_infrared_request_flags,
  input wire logic [7:0]                 converter_serial_request_flags
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence rd_ext_s;
    rd_en && addr == irf_pkg::OFF_EXT_FLAGS;
  endsequence
  sequence rd_dma_s;
    rd_en && addr == irf_pkg::OFF_DMA_IR;
  endsequence
  sequence rd_conv_s;
    rd_en && addr == irf_pkg::OFF_CONV_SER;
  endsequence
  // Reset and standby both break the one-cycle mirror path
  sequence live_s;
    !standby && !manual_reset;
  endsequence

  reset_clear_a: assert property (manual_reset |=> external_request_flags == 8'h00 &&
    dma_infrared_request_flags == 8'h00 && converter_serial_request_flags == 8'h00)
    else $error("flags not cleared by manual reset");
  standby_hold_a: assert property (standby && !manual_reset |=>
    $stable(external_request_flags) && $stable(dma_infrared_request_flags)
    && $stable(converter_serial_request_flags))
    else $error("flags moved in standby");
  dma_mirror_a: assert property (live_s |=>
    dma_infrared_request_flags == $past({infrared_req, dma_end_req}))
    else $error("dma and infrared mirror wrong");
  conv_mirror_a: assert property (live_s |=>
    converter_serial_request_flags == {3'h0, $past(conversion_end_req), $past(fifo_serial_req)})
    else $error("converter and serial mirror wrong");
  reserved_zero_a: assert property (converter_serial_request_flags[7:5] == 3'h0)
    else $error("reserved bits not zero");
  read_ext_a: assert property (rd_ext_s |=>
    rd_data == {8'h00, $past(external_request_flags)})
    else $error("external flag read wrong");
  read_dma_a: assert property (rd_dma_s |=>
    rd_data == {8'h00, $past(dma_infrared_request_flags)})
    else $error("dma flag read wrong");
  read_conv_a: assert property (rd_conv_s |=>
    rd_data == {8'h00, $past(converter_serial_request_flags)})
    else $error("converter flag read wrong");
  read_idle_a: assert property (!rd_en |=> rd_data == 16'h0000)
    else $error("read data outside read slot");
endmodule

// [bench/irf_src_model.sv]
// Model: request sources and pins that face the flag block
`timescale 1ns/1ps
module irf_src_model (
  input  wire logic        clock,
  input  wire logic [34:0] want,
  output logic      [34:0] drive
);
  // --------------------
  // Source outputs
  // --------------------
  // Sources are registered logic elsewhere, so levels move just after an edge
  always_ff @(posedge clock) begin
    drive <= want;
  end
endmodule

// [bench/irf_top_tb.sv]
// Testbench: self-checking bench of the request flag block
`timescale 1ns/1ps
module irf_top_tb;
  logic                       clock = 1'b0;
  logic                       srst = 1'b1;
  logic                       manual_reset = 1'b0;
  logic                       standby = 1'b0;
  logic [5:0]                 ext_w = 6'h3F;
  logic [15:0]                port_w = 16'hFDFF;
  logic [3:0]                 dma_w = 4'h0;
  logic [3:0]                 ir_w = 4'h0;
  logic [3:0]                 fifo_w = 4'h0;
  logic                       conv_w = 1'b0;
  logic [irf_pkg::ADDR_W-1:0] addr = 4'h0;
  logic [irf_pkg::DATA_W-1:0] wr_data = 16'h0000;
  logic                       wr_en = 1'b0;
  logic                       rd_en = 1'b0;
  wire  [34:0]                drv;
  wire  [15:0]                rd_data;
  wire                        irq;
  wire  [7:0]                 external_request_flags;
  wire  [7:0]                 dma_infrared_request_flags;
  wire  [7:0]                 converter_serial_request_flags;
  int                         mismatches = 0;
  int                         checks = 0;
  // Row: dma, infrared, fifo serial, converter, then expected mirror bytes
  logic [31:0] rows [5] = '{32'h1000_0100, 32'h8121_1812, 32'h0FF0_F00F,
                            32'hF811_8F11, 32'h0000_0000};
  logic [15:0] pins [4] = '{16'hFDFD, 16'hFDFC, 16'hFFFC, 16'hFDFF};
  logic [7:0]  grp [4] = '{8'h01, 8'h81, 8'hC1, 8'h01};

  irf_src_model src_u (
    .clock (clock),
    .want  ({ext_w, port_w, dma_w, ir_w, fifo_w, conv_w}),
    .drive (drv)
  );
  irf_top dut_u (
    .clock, .srst, .manual_reset, .standby,
    .ext_request_line         (drv[34:29]),
    .port_level_interrupt_pin (drv[28:13]),
    .dma_end_req              (drv[12:9]),
    .infrared_req             (drv[8:5]),
    .fifo_serial_req          (drv[4:1]),
    .conversion_end_req       (drv[0]),
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq, .external_request_flags,
    .dma_infrared_request_flags, .converter_serial_request_flags
  );

  // --------------------
  // Tasks
  // --------------------
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Flag outputs settle after the edge, so look 1 ns later
  task automatic ext(input logic [7:0] e);
    #1 chk({8'h00, external_request_flags}, {8'h00, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end

  // --------------------
  // Sequence
  // --------------------
  initial begin
    cyc(5);
    srst <= 1'b0;
    cyc(6);
    for (int i = 0; i < 3; i++) rd(4'(i), 16'h0000);
    rd(4'hF, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clock);
      {dma_w, ir_w, fifo_w} <= rows[i][31:20];
      conv_w <= rows[i][16];
      wr(irf_pkg::OFF_DMA_IR, 16'hFFFF);
      wr(irf_pkg::OFF_CONV_SER, 16'h001F);
      rd(irf_pkg::OFF_DMA_IR, {8'h00, rows[i][15:8]});
      rd(irf_pkg::OFF_CONV_SER, {8'h00, rows[i][7:0]});
    end
    // Falling edges on lines 0 and 1 latch, and stay after the pins recover
    ext_w <= 6'h3C;
    cyc(8);
    ext(8'h03);
    ext_w <= 6'h3F;
    cyc(8);
    ext(8'h03);
    wr(irf_pkg::OFF_EXT_FLAGS, 16'h00FC);
    ext(8'h03);
    rd(irf_pkg::OFF_EXT_FLAGS, 16'h0003);
    wr(irf_pkg::OFF_EXT_FLAGS, 16'h00FE);
    ext(8'h02);
    rd(irf_pkg::OFF_EXT_FLAGS, 16'h0002);
    wr(irf_pkg::OFF_EXT_FLAGS, 16'h00FD);
    ext(8'h00);
    // Line 2 rising, line 3 low level, line 4 reserved code
    wr(irf_pkg::OFF_LINE_SENSE, 16'h0390);
    rd(irf_pkg::OFF_LINE_SENSE, 16'h0390);
    ext_w <= 6'h23;
    cyc(8);
    ext(8'h08);
    // A level flag cannot be written clear while its pin stays low
    rd(irf_pkg::OFF_EXT_FLAGS, 16'h0008);
    wr(irf_pkg::OFF_EXT_FLAGS, 16'h00F7);
    ext(8'h08);
    ext_w <= 6'h3F;
    cyc(8);
    ext(8'h04);
    rd(irf_pkg::OFF_EXT_FLAGS, 16'h0004);
    wr(irf_pkg::OFF_EXT_FLAGS, 16'h00FB);
    ext(8'h00);
    // Interrupt: sticky status, mask, clear on read
    rd(irf_pkg::OFF_IRQ_STATUS, 16'h000F);
    wr(irf_pkg::OFF_IRQ_MASK, 16'h0001);
    ext_w <= 6'h3E;
    cyc(10);
    #1 chk({15'h0000, irq}, 16'h0001);
    rd(irf_pkg::OFF_IRQ_STATUS, 16'h0001);
    cyc(2);
    #1 chk({15'h0000, irq}, 16'h0000);
    // Pin 0 low-sensed, pin 9 high-sensed, pin 1 disabled
    wr(irf_pkg::OFF_PORT_SENSE, 16'h0200);
    wr(irf_pkg::OFF_PORT_ENABLE, 16'h0201);
    rd(irf_pkg::OFF_PORT_ENABLE, 16'h0201);
    foreach (pins[i]) begin
      port_w <= pins[i];
      cyc(8);
      ext(grp[i]);
    end
    standby <= 1'b1;
    dma_w <= 4'h5;
    cyc(6);
    #1 chk({8'h00, dma_infrared_request_flags}, 16'h0000);
    standby <= 1'b0;
    cyc(3);
    #1 chk({8'h00, dma_infrared_request_flags}, 16'h0005);
    for (int k = 0; k < 2; k++) begin
      manual_reset <= (k == 0);
      srst <= (k == 1);
      cyc(2);
      #1 chk({external_request_flags, dma_infrared_request_flags}, 16'h0000);
      manual_reset <= 1'b0;
      srst <= 1'b0;
      cyc(6);
      rd(irf_pkg::OFF_PORT_ENABLE, 16'h0000);
    end
    conclude();
  end
endmodule

bind irf_top irf_props props_u (
  .clock, .srst, .manual_reset, .standby, .ext_request_line, .port_level_interrupt_pin,
  .dma_end_req, .infrared_req, .fifo_serial_req, .conversion_end_req, .addr, .wr_data,
  .wr_en, .rd_en, .rd_data, .irq, .external_request_flags, .dma_infrared_request_flags,
  .converter_serial_request_flags
);
